/* hw/ctw_pkg.sv */
// Purpose: Shared constants for the transceiver mode and wake-up block
// Assumes: 20 MHz system clock
// Notes:   Times are kept in their own units; cycle counts derive from them
package ctw_pkg;

  // ----------------------------------------------------------------------
  // Device power modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_RESET,
    DEV_NORMAL_REQ,
    DEV_NORMAL,
    DEV_STANDBY,
    DEV_SLEEP,
    DEV_STOP
  } ctw_dev_mode_t;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int PULSE_MIN_NS    = 500;
  localparam int PULSE_MAX_US    = 500;
  localparam int GAP_MAX_US      = 500;
  localparam int WINDOW_MAX_US   = 1000;
  localparam int PULSES_NEEDED   = 3;
  // Least time rounds up, longest time rounds down
  localparam int PULSE_MIN_CYC   =
    (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_MAX_CYC   = PULSE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int GAP_MAX_CYC     = GAP_MAX_US * (CLK_HZ / 1_000_000);
  localparam int WINDOW_MAX_CYC  = WINDOW_MAX_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W           = 16;
  localparam int PULSE_CNT_W     = 2;

  // Reset values
  localparam logic [1:0] SLEW_RST = 2'h0;

endpackage

/* hw/ctw_pattern_det.sv */
// Purpose: Three-pulse dominant wake-up pattern detector
// Assumes: dominant_i high while the wake-up receiver sees dominant
// Notes:   Emits a one-cycle detect pulse on the accepting pulse end
`timescale 1ns/1ps
`default_nettype none
module ctw_pattern_det #(
  parameter int PULSE_MIN  = ctw_pkg::PULSE_MIN_CYC,
  parameter int PULSE_MAX  = ctw_pkg::PULSE_MAX_CYC,
  parameter int GAP_MAX    = ctw_pkg::GAP_MAX_CYC,
  parameter int WINDOW_MAX = ctw_pkg::WINDOW_MAX_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic dominant_i,
  output logic      detect_o
);

  logic [ctw_pkg::CNT_W-1:0]       width_q, width_d;
  logic [ctw_pkg::CNT_W-1:0]       gap_q, gap_d;
  logic [ctw_pkg::CNT_W-1:0]       win_q, win_d;
  logic [ctw_pkg::PULSE_CNT_W-1:0] npulse_q, npulse_d;
  logic                            dom_q, dom_d;
  logic                            det_q, det_d;
  logic                            pulse_ok;

  function automatic logic [ctw_pkg::CNT_W-1:0] sat_inc(
    input logic [ctw_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 16'h0001;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Width must exceed min and stay under max
  assign pulse_ok = (width_q > PULSE_MIN[ctw_pkg::CNT_W-1:0]) &&
                    (width_q < PULSE_MAX[ctw_pkg::CNT_W-1:0]);

  always_comb begin
    width_d  = width_q;
    gap_d    = gap_q;
    win_d    = win_q;
    npulse_d = npulse_q;
    dom_d    = dominant_i;
    det_d    = 1'b0;
    if (!enable_i) begin
      // Disabled receiver ignores all traffic
      width_d  = '0;
      gap_d    = '0;
      win_d    = '0;
      npulse_d = '0;
      dom_d    = 1'b0;
    end else begin
      // Window runs from the first pulse start, so that pulse counts too
      if (npulse_q != '0 || dom_q) begin
        win_d = sat_inc(win_q);
      end
      if (dominant_i) begin
        width_d = sat_inc(width_q);
        if (!dom_q && npulse_q == '0) begin
          win_d = '0;                        // Window opens at pulse start
        end
      end else begin
        gap_d = sat_inc(gap_q);
      end
      if (dom_q && !dominant_i) begin
        // Falling edge of dominant: judge the pulse
        width_d = '0;
        gap_d   = 16'h0001;          // The judging cycle is the first low one
        if (pulse_ok && win_q < WINDOW_MAX[ctw_pkg::CNT_W-1:0]) begin
          if (npulse_q == 2'(ctw_pkg::PULSES_NEEDED - 1)) begin
            det_d    = 1'b1;
            npulse_d = '0;
          end else begin
            npulse_d = npulse_q + 2'h1;
          end
        end else begin
          npulse_d = '0;
        end
      end else if (npulse_q != '0 && !dominant_i &&
                   (gap_q >= GAP_MAX[ctw_pkg::CNT_W-1:0] - 16'h0001 ||
                    win_q >= WINDOW_MAX[ctw_pkg::CNT_W-1:0])) begin
        npulse_d = '0;
      end
      if (dominant_i && width_q >= PULSE_MAX[ctw_pkg::CNT_W-1:0]) begin
        npulse_d = '0;
      end
    end
  end

  // Register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      width_q  <= '0;
      gap_q    <= '0;
      win_q    <= '0;
      npulse_q <= '0;
      dom_q    <= 1'b0;
      det_q    <= 1'b0;
    end else begin
      width_q  <= width_d;
      gap_q    <= gap_d;
      win_q    <= win_d;
      npulse_q <= npulse_d;
      dom_q    <= dom_d;
      det_q    <= det_d;
    end
  end

  assign detect_o = det_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_silent_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !det_q) else $error("detect while disabled");
  a_count_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    npulse_q != 2'h3) else $error("pulse count overflow");
  a_detect_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    det_q |-> $past(dom_q) && !$past(dominant_i))
    else $error("detect not at pulse end");
  c_detect: cover property (@(posedge clk_i) disable iff (rst_i) det_q);

endmodule
`default_nettype wire

/* hw/ctw_top.sv */
// Purpose: Mode control and pattern wake-up of a high-speed bus interface
// Assumes: All pins synchronous to CLK_SYS_I; modes set by a command port
// Notes:   Analogue states (bus float, recessive) appear as status outputs
`timescale 1ns/1ps
`default_nettype none
module ctw_top (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_I,
  input  wire logic [2:0] DEV_MODE_I,        // ctw_dev_mode_t code
  input  wire logic       BALLAST_I,         // High: external ballast
  input  wire logic       MODE_WR_I,         // Command strobe
  input  wire logic       MODE_SLEEP_I,      // 1 sleep, 0 normal
  input  wire logic [1:0] SLEW_I,
  input  wire logic       WAKE_EN_I,
  input  wire logic       STATUS_RD_I,       // Transceiver register read
  input  wire logic       TX_I,              // Transmit pin from host
  input  wire logic       BUS_DOMINANT_I,    // Receiver comparator
  output logic            RX_O,
  output logic            TX_LEVEL_O,        // Pull-up level seen on pin
  output logic            DRIVE_DOM_O,       // Drive bus dominant
  output logic            BIAS_RECESSIVE_O,  // Bias lines to mid level
  output logic            BUS_FLOAT_O,
  output logic            SLEEP_O,           // Transceiver mode status
  output logic [1:0]      SLEW_O,
  output logic            WAKE_RX_ON_O,
  output logic            BUS_WAKEUP_FLAG_O,
  output logic            REG_ON_O,          // Main regulator turn-on
  output logic            WAKE_INT_O         // Interrupt pulse
);

  logic                  sleep_q, sleep_d;
  logic [1:0]            slew_q, slew_d;
  logic                  wen_q, wen_d;
  logic                  flag_q, flag_d;
  logic                  reg_on_q, reg_on_d;
  logic                  int_q, int_d;
  logic                  rx_q, rx_d;
  logic                  txl_q, txl_d;
  logic                  drv_q, drv_d;
  logic                  bias_q, bias_d;
  logic                  flt_q, flt_d;
  logic                  wrx_q, wrx_d;
  logic                  supply_on;
  logic                  wake_det;
  logic                  dev_reset;
  ctw_pkg::ctw_dev_mode_t dev;

  assign dev = ctw_pkg::ctw_dev_mode_t'(DEV_MODE_I);

  // ----------------------------------------------------------------------
  // Peripheral supply state
  // ----------------------------------------------------------------------
  // Supply is on in normal, or standby when tied to the main regulator
  function automatic logic supply_live(input ctw_pkg::ctw_dev_mode_t m,
                                       input logic ballast);
    case (m)
      ctw_pkg::DEV_NORMAL:  supply_live = 1'b1;
      ctw_pkg::DEV_STANDBY: supply_live = !ballast;
      default:              supply_live = 1'b0;
    endcase
  endfunction

  assign supply_on = supply_live(dev, BALLAST_I);
  assign dev_reset = (dev == ctw_pkg::DEV_RESET) ||
                     (dev == ctw_pkg::DEV_NORMAL_REQ);

  // ----------------------------------------------------------------------
  // Mode, slew, wake enable and flag
  // ----------------------------------------------------------------------
  always_comb begin
    sleep_d  = sleep_q;
    slew_d   = slew_q;
    wen_d    = wen_q;
    flag_d   = flag_q;
    reg_on_d = reg_on_q;
    int_d    = 1'b0;
    if (dev_reset) begin
      sleep_d = 1'b0;
      slew_d  = ctw_pkg::SLEW_RST;
    end else if (dev == ctw_pkg::DEV_SLEEP ||
                 dev == ctw_pkg::DEV_STOP) begin
      sleep_d = 1'b1;                    // Low power forces sleep mode
    end else if (MODE_WR_I) begin
      sleep_d = MODE_SLEEP_I;
      slew_d  = SLEW_I;
      // Enable is taken with the command; host orders it first
      wen_d   = WAKE_EN_I;
    end
    if (dev != ctw_pkg::DEV_SLEEP) begin
      reg_on_d = 1'b0;
    end
    // Clear needs normal mode plus read; a new wake wins
    if (STATUS_RD_I && !sleep_q) begin
      flag_d = 1'b0;
    end
    if (wake_det) begin
      flag_d = 1'b1;
      case (dev)
        ctw_pkg::DEV_SLEEP: reg_on_d = 1'b1;
        ctw_pkg::DEV_STOP:  int_d    = 1'b1;
        default:            int_d    = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin and bus states
  // ----------------------------------------------------------------------
  always_comb begin
    rx_d   = 1'b0;
    txl_d  = 1'b0;
    drv_d  = 1'b0;
    bias_d = 1'b0;
    flt_d  = 1'b1;
    wrx_d  = 1'b0;
    if (!supply_on) begin
      rx_d  = 1'b0;
      txl_d = 1'b0;
      wrx_d = sleep_q && wen_q;
    end else if (sleep_q) begin
      rx_d  = 1'b1;
      txl_d = 1'b1;
      wrx_d = wen_q;
    end else begin
      rx_d   = !BUS_DOMINANT_I;
      txl_d  = TX_I;
      drv_d  = !TX_I;
      bias_d = 1'b1;
      flt_d  = 1'b0;
    end
  end

  // Detector runs only when the wake receiver is active
  ctw_pattern_det u_det (
    .clk_i      (CLK_SYS_I),
    .rst_i      (RST_I),
    .enable_i   (wrx_q),
    .dominant_i (BUS_DOMINANT_I),
    .detect_o   (wake_det)
  );

  // Register all state and outputs
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sleep_q  <= 1'b0;
      slew_q   <= ctw_pkg::SLEW_RST;
      wen_q    <= 1'b0;
      flag_q   <= 1'b0;
      reg_on_q <= 1'b0;
      int_q    <= 1'b0;
      rx_q     <= 1'b0;
      txl_q    <= 1'b0;
      drv_q    <= 1'b0;
      bias_q   <= 1'b0;
      flt_q    <= 1'b1;
      wrx_q    <= 1'b0;
    end else begin
      sleep_q  <= sleep_d;
      slew_q   <= slew_d;
      wen_q    <= wen_d;
      flag_q   <= flag_d;
      reg_on_q <= reg_on_d;
      int_q    <= int_d;
      rx_q     <= rx_d;
      txl_q    <= txl_d;
      drv_q    <= drv_d;
      bias_q   <= bias_d;
      flt_q    <= flt_d;
      wrx_q    <= wrx_d;
    end
  end

  assign RX_O              = rx_q;
  assign TX_LEVEL_O        = txl_q;
  assign DRIVE_DOM_O       = drv_q;
  assign BIAS_RECESSIVE_O  = bias_q;
  assign BUS_FLOAT_O       = flt_q;
  assign SLEEP_O           = sleep_q;
  assign SLEW_O            = slew_q;
  assign WAKE_RX_ON_O      = wrx_q;
  assign BUS_WAKEUP_FLAG_O = flag_q;
  assign REG_ON_O          = reg_on_q;
  assign WAKE_INT_O        = int_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_rx_follows_bus: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (supply_on && !sleep_q) |=> (rx_q == !$past(BUS_DOMINANT_I)))
    else $error("rx does not follow bus");
  a_reset_normal: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    dev_reset |=> !sleep_q && slew_q == ctw_pkg::SLEW_RST)
    else $error("not normal slew zero");
  a_off_pins_low: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !supply_on |=> !rx_q && !txl_q && flt_q)
    else $error("pins not low with supply off");
  a_sleep_high: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (supply_on && sleep_q) |=> rx_q && txl_q && flt_q && !drv_q)
    else $error("sleep pins wrong");
  a_wake_rx_gate: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wrx_q |-> $past(wen_q) && !drv_q && !bias_q)
    else $error("wake receiver without enable");
  a_regulator_on: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (wake_det && dev == ctw_pkg::DEV_SLEEP) |=> reg_on_q)
    else $error("no regulator turn-on");
  a_int_pulse: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (wake_det && dev == ctw_pkg::DEV_STOP) |=> int_q ##1 !int_q)
    else $error("interrupt pulse wrong");
  a_flag_set: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wake_det |=> flag_q) else $error("flag not set");
  a_flag_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (flag_q && (sleep_q || !STATUS_RD_I)) |=> flag_q)
    else $error("flag cleared early");
  c_sleep_wake: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    reg_on_q && !$past(reg_on_q));
  c_stop_int: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    int_q);
  c_flag_clear: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $fell(flag_q));

endmodule
`default_nettype wire

/* verification/ctw_bus_model.sv */
// Purpose: Far side of the transceiver: shared bus with a remote node
// Assumes: Dominant wins over recessive on the shared lines
// Notes:   slow_i adds one cycle of bus delay to the level seen back
`timescale 1ns/1ps
`default_nettype none
module ctw_bus_model (
  input  wire logic clk_i,
  input  wire logic drive_dom_i,
  input  wire logic remote_dom_i,
  input  wire logic slow_i,
  output logic      bus_dom_o
);
  // ----------------------------------------------------------------------
  // Bus level
  // ----------------------------------------------------------------------
  logic bus_q;

  // Delayed copy for the slow answer
  always_ff @(posedge clk_i) begin
    bus_q <= drive_dom_i | remote_dom_i;
  end

  // Either node pulling dominant makes the bus dominant
  assign bus_dom_o = slow_i ? bus_q : (drive_dom_i | remote_dom_i);
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the mode and wake-up block
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Expected output sets queue up; a monitor compares them
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module tb_top;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam logic [11:0] M_RX = 12'h001, M_TXL = 12'h002, M_DRV = 12'h004;
  localparam logic [11:0] M_BIAS = 12'h008, M_FLT = 12'h010, M_SLP = 12'h020;
  localparam logic [11:0] M_WRX = 12'h040, M_FLG = 12'h080, M_REG = 12'h100;
  localparam logic [11:0] M_SLW = 12'h600, M_INT = 12'h800;
  logic        clk = 0, rst = 1, ballast = 1, mode_wr = 0, mode_sleep = 0;
  logic        wake_en = 0, status_rd = 0, tx = 1, remote = 0, slow = 0;
  logic [2:0]  dev_mode = 3'h1;
  logic [1:0]  slew = 2'h0, slew_o;
  logic        rx, txl, drv, bias, flt, slp, wrx, flg, reg_on, wint, bus;
  logic [11:0] obs;
  logic [23:0] note;
  logic [23:0] notes[$];
  int          num_errors = 0, checks_done = 0, cyc = 0, seed = 89;
  int          int_cnt = 0, int_base = 0, w;
  event        obs_ev;

  // Clock and observed output set
  always #25 clk = ~clk;
  assign obs = {(int_cnt - int_base) == 1, slew_o, reg_on, flg, wrx, slp,
                flt, bias, drv, txl, rx};

  ctw_top ctw_top_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .DEV_MODE_I(dev_mode),
    .BALLAST_I(ballast), .MODE_WR_I(mode_wr), .MODE_SLEEP_I(mode_sleep),
    .SLEW_I(slew), .WAKE_EN_I(wake_en), .STATUS_RD_I(status_rd),
    .TX_I(tx), .BUS_DOMINANT_I(bus), .RX_O(rx), .TX_LEVEL_O(txl),
    .DRIVE_DOM_O(drv), .BIAS_RECESSIVE_O(bias), .BUS_FLOAT_O(flt),
    .SLEEP_O(slp), .SLEW_O(slew_o), .WAKE_RX_ON_O(wrx),
    .BUS_WAKEUP_FLAG_O(flg), .REG_ON_O(reg_on), .WAKE_INT_O(wint));

  ctw_bus_model ctw_bus_model_inst (
    .clk_i(clk), .drive_dom_i(drv), .remote_dom_i(remote),
    .slow_i(slow), .bus_dom_o(bus));

  // ----------------------------------------------------------------------
  // Monitor, pulse counter and timeout
  // ----------------------------------------------------------------------
  always @(obs_ev) begin
    while (notes.size() > 0) begin
      note = notes.pop_front();
      `CHK(obs & note[23:12], note[11:0])
    end
  end

  always @(posedge clk) begin
    if (wint === 1'b1) int_cnt++;
    cyc++;
    if (cyc == 70000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic expect_out(input logic [11:0] m, input logic [11:0] e);
    notes.push_back({m, e});
    ->obs_ev;
  endtask

  // Mode command: one strobe, then let the pins settle
  task automatic cmd(input logic sl, input logic [1:0] sw, input logic we);
    mode_sleep = sl;
    slew = sw;
    wake_en = we;
    mode_wr = 1;
    tick(1);
    mode_wr = 0;
    tick(3);
  endtask

  // Remote node sends dominant pulses of width wd, gap g
  task automatic pattern(input int wd, input int g, input int n);
    for (int i = 0; i < n; i++) begin
      remote = 1;
      tick(wd);
      remote = 0;
      tick(g);
    end
  endtask

  task automatic status_read();
    status_rd = 1;
    tick(1);
    status_rd = 0;
    tick(2);
  endtask

  // Random transmit and remote levels; receive must track the bus
  task automatic follow(input int n);
    for (int i = 0; i < n; i++) begin
      tx = $random(seed);
      remote = $random(seed);
      tick(4);
      expect_out(M_RX | M_DRV | M_FLT,
        (tx && !remote) ? M_RX : (tx ? 12'h000 : M_DRV));
    end
    tx = 1;
    remote = 0;
    tick(4);
  endtask

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #2;
    rst = 0;
    tick(3);
    // Normal request: supply off, transceiver normal with slew zero
    expect_out(M_SLP | M_SLW | M_RX | M_TXL | M_FLT, M_FLT);
    dev_mode = 3'h2;
    tick(3);
    follow(8);
    for (int i = 3; i >= 0; i--) begin
      cmd(0, 2'(i), 0);
      expect_out(M_SLW | M_SLP | M_TXL, {1'b0, 2'(i), 9'h002});
    end
    // Standby without ballast behaves as normal, slow bus answer
    dev_mode = 3'h3;
    ballast = 0;
    slow = 1;
    tick(3);
    follow(6);
    slow = 0;
    dev_mode = 3'h2;
    ballast = 1;
    // Sleep with wake-up disabled: pins high, bus ignored
    cmd(1, 0, 0);
    tx = 0;
    tick(3);
    expect_out(M_RX | M_TXL | M_FLT | M_DRV | M_WRX | M_SLP,
               M_RX | M_TXL | M_FLT | M_SLP);
    pattern(20, 20, 3);
    expect_out(M_FLG | M_DRV, 12'h000);
    tx = 1;
    // Enable wake-up before entering sleep
    cmd(0, 0, 1);
    cmd(1, 0, 1);
    expect_out(M_WRX, M_WRX);
    pattern(10, 20, 3);
    expect_out(M_FLG, 12'h000);
    pattern(500, 9495, 3);
    expect_out(M_FLG, 12'h000);
    pattern(11, 20, 3);
    expect_out(M_FLG, M_FLG);
    status_read();
    expect_out(M_FLG, M_FLG);
    cmd(0, 0, 1);
    expect_out(M_FLG | M_BIAS | M_FLT, M_FLG | M_BIAS);
    status_read();
    expect_out(M_FLG, 12'h000);
    // Device sleep: wake-up turns the regulator on
    cmd(1, 0, 1);
    dev_mode = 3'h4;
    tick(3);
    expect_out(M_RX | M_TXL | M_FLT | M_REG, M_FLT);
    w = 11 + ({$random(seed)} % 30);
    pattern(w, 9000, 3);
    expect_out(M_REG | M_FLG, M_REG | M_FLG);
    dev_mode = 3'h2;
    tick(3);
    expect_out(M_REG, 12'h000);
    cmd(0, 0, 1);
    status_read();
    // Device stop: wake-up gives one interrupt pulse
    cmd(1, 0, 1);
    dev_mode = 3'h5;
    tick(3);
    int_base = int_cnt;
    w = 11 + ({$random(seed)} % 30);
    pattern(w, 40, 3);
    expect_out(M_INT | M_REG | M_FLG, M_INT | M_FLG);
    tick(2);
    conclude();
  end
endmodule
`default_nettype wire
